// File: rtl/pioc_pkg.sv
// Package for the port I/O cell configuration block
package pioc_pkg;
  // Pin count: P0.0..P3.7 plus P4.0
  localparam int PIOC_NPINS = 33;
  // Number of crossbar peripheral signals routed by the priority decoder
  localparam int PIOC_NPERIPH = 24;
  // Index of the pin shared with the debug data line
  localparam int PIOC_DBG_PIN = 32;
  // Register byte offsets
  localparam logic [7:0] PIOC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PIOC_OFS_MDIN = 8'h04;
  localparam logic [7:0] PIOC_OFS_MDOUT = 8'h08;
  localparam logic [7:0] PIOC_OFS_LATCH = 8'h0C;
  localparam logic [7:0] PIOC_OFS_PADIN = 8'h10;
  localparam logic [7:0] PIOC_OFS_XSEL0 = 8'h14;
  localparam logic [7:0] PIOC_OFS_XSEL1 = 8'h18;
  localparam logic [7:0] PIOC_OFS_XSEL2 = 8'h1C;
  localparam logic [7:0] PIOC_OFS_MDIN_HI = 8'h20;
  localparam logic [7:0] PIOC_OFS_MDOUT_HI = 8'h24;
  localparam logic [7:0] PIOC_OFS_LATCH_HI = 8'h28;
  localparam logic [7:0] PIOC_OFS_PADIN_HI = 8'h2C;
  // Control register bit positions
  localparam int PIOC_BIT_XBAR_EN = 0;
  localparam int PIOC_BIT_PU_DIS = 1;
  // Reset values
  localparam logic [32:0] PIOC_RST_MDIN = 33'h1FFFFFFFF;
  localparam logic [32:0] PIOC_RST_MDOUT = 33'h000000000;
  localparam logic [32:0] PIOC_RST_LATCH = 33'h1FFFFFFFF;
  localparam logic [1:0] PIOC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIOC_RESP_SLVERR = 2'h2;

  // Pad-side signals of one group
  typedef struct packed {
    logic [PIOC_NPINS-1:0] out;   // Output level
    logic [PIOC_NPINS-1:0] oe;    // Output enable
    logic [PIOC_NPINS-1:0] pu;    // Weak pull-up enable
    logic [PIOC_NPINS-1:0] ie;    // Digital receiver enable
  } pioc_pad_type;

  // Peripheral side of the crossbar
  typedef struct packed {
    logic [PIOC_NPERIPH-1:0] out; // Peripheral output value
    logic [PIOC_NPERIPH-1:0] oe;  // Peripheral wants to drive
  } pioc_periph_type;

  // Bus slave states
  typedef enum logic [1:0] {
    PIOC_IDLE = 2'b00,
    PIOC_RESP = 2'b01
  } pioc_bus_state_type;
endpackage

// File: rtl/pioc_sync.sv
// Two-stage synchroniser for one vector of pad inputs
`timescale 1ns/1ps
module pioc_sync #(
  parameter int WIDTH = 33
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] d, // Asynchronous pad levels
  output logic [WIDTH-1:0] q // Synchronised levels
);
  import pioc_pkg::*;
  // Stage one feeds stage two only, avoiding metastable fan-out
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // pioc_sync

// File: rtl/pioc_top.sv
// Port I/O cell configuration, crossbar and register slave
// Notes on behaviour
// - Reset: all cells Hi-Z, pull-ups on until crossbar enabled
// - Input-mode bit 0 selects analog pin
// - Analog pin: pull-up, driver, receiver off
// - Analog pin reads logic 0
// - Pad state always readable via latch register
// - Output-mode bits select push-pull or open-drain
// - Three select registers feed priority crossbar
// - Pins serve as GPIO, peripheral, or analog
// - Top pin shared with debug data line
// - Push-pull drives both; open-drain drives low only
// - Pull-up off when driving low, or globally disabled while crossbar enabled
// - Digital pin reads actual pad level
// - Input-mode bit 1 selects digital operation
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pioc_top #(
  parameter int NPINS = 33, // Port pins
  parameter int NPERIPH = 24 // Crossbar peripheral signals
) (
  input wire logic aclk, // System clock 200 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [NPINS-1:0] pad_in, // Pad input levels
  output pioc_pkg::pioc_pad_type pad, // Pad driver controls
  input wire pioc_pkg::pioc_periph_type periph, // Peripheral drive requests
  output logic [NPERIPH-1:0] periph_in, // Synchronised pad levels to peripherals
  input wire logic debug_link_data_oe, // Debug link drives shared pin
  input wire logic debug_link_data_out, // Debug link output value
  output logic debug_link_data_in // Synchronised shared pin level
);
  import pioc_pkg::*;

  // All state in one struct
  typedef struct packed {
    pioc_bus_state_type wst; // Write channel state
    pioc_bus_state_type rst; // Read channel state
    logic aw_got; // Write address captured
    logic w_got; // Write data captured
    logic [7:0] awaddr; // Captured write address
    logic [31:0] wdata; // Captured write data
    logic [3:0] wstrb; // Captured strobes
    logic [1:0] bresp; // Write response code
    logic [31:0] rdata; // Read data
    logic [1:0] rresp; // Read response code
    logic crossbar_enable; // Crossbar enable bit
    logic global_pullup_disable; // Global weak pull-up disable
    logic [NPINS-1:0] pin_input_mode_bits; // 1 digital, 0 analog
    logic [NPINS-1:0] pin_output_mode_bits; // 1 push-pull, 0 open-drain
    logic [NPINS-1:0] latch; // Port output latch
    logic [7:0] crossbar_select_first; // Peripheral enables 0..7
    logic [7:0] crossbar_select_second; // Peripheral enables 8..15
    logic [7:0] crossbar_select_third; // Peripheral enables 16..23
    pioc_pad_type pad; // Registered pad controls
    logic [NPERIPH-1:0] pin_to_periph; // Registered peripheral inputs
    logic dbg_in; // Registered debug input
    logic aw_rdy, w_rdy, ar_rdy, b_vld, r_vld; // Registered handshake outputs
  } pioc_state_type;

  pioc_state_type st_r, st_nxt;
  logic [NPINS-1:0] pad_sync; // Synchronised pad levels
  logic [NPINS-1:0] pin_read; // Value seen by latch reads
  logic [NPERIPH-1:0] xbar_en; // Enabled peripherals
  logic [NPINS-1:0] xbar_claim; // Pin claimed by crossbar
  logic [NPINS-1:0] xbar_out; // Crossbar output value per pin
  logic [NPINS-1:0] xbar_oe; // Crossbar drive request per pin
  logic [NPINS-1:0] drv_val; // Final output value per pin
  logic [NPINS-1:0] drv_req; // Pin wants to drive
  logic [NPERIPH-1:0] periph_pin; // Pad level of the pin assigned to each peripheral

  // Pad inputs cross into the system clock domain
  pioc_sync #(.WIDTH(NPINS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(pad_in),
    .q(pad_sync)
  );

  // Pad read-back: analog pins read zero, digital pins read the pad
  assign pin_read = pad_sync & st_r.pin_input_mode_bits;

  // Priority crossbar: each enabled peripheral, in index order, takes the next free digital pin
  always_comb begin
    int unsigned p;
    p = 0;
    xbar_claim = '0;
    xbar_out = '0;
    xbar_oe = '0;
    periph_pin = '0;
    xbar_en = {st_r.crossbar_select_third, st_r.crossbar_select_second,
               st_r.crossbar_select_first};
    // Lower peripheral index wins lower pin; debug pin never claimed
    for (int k = 0; k < NPERIPH; k++) begin
      // Skip analog pins so they stay free for analog use
      while (p < NPINS - 1 && !st_r.pin_input_mode_bits[p]) p++;
      if (xbar_en[k] && st_r.crossbar_enable && p < NPINS - 1) begin
        xbar_claim[p] = 1'b1;
        xbar_out[p] = periph.out[k];
        xbar_oe[p] = periph.oe[k];
        periph_pin[k] = pin_read[p];
        p++;
      end
    end
  end

  // Output value and drive request per pin
  always_comb begin
    drv_val = '0;
    drv_req = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (xbar_claim[i]) begin
        drv_val[i] = xbar_out[i];
        drv_req[i] = xbar_oe[i];
      end else begin
        drv_val[i] = st_r.latch[i]; // GPIO from latch
        drv_req[i] = 1'b1;
      end
    end
    // Debug link takes the shared pin over GPIO while active
    if (debug_link_data_oe) begin
      drv_val[PIOC_DBG_PIN] = debug_link_data_out;
      drv_req[PIOC_DBG_PIN] = 1'b1;
    end
  end

  // Next-state logic: bus slave, registers and pad controls
  always_comb begin
    logic [31:0] rd;
    logic [7:0] a;
    logic ok;
    rd = '0;
    a = '0;
    ok = 1'b0;
    st_nxt = st_r;
    // Write channel: accept address and data in any order
    if (st_r.wst == PIOC_IDLE) begin
      if (s_axi_awvalid && !st_r.aw_got) begin
        st_nxt.aw_got = 1'b1;
        st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_got) begin
        st_nxt.w_got = 1'b1;
        st_nxt.wdata = s_axi_wdata;
        st_nxt.wstrb = s_axi_wstrb;
      end
      if (st_r.aw_got && st_r.w_got) begin
        a = st_r.awaddr;
        ok = 1'b1;
        // Only the low byte lane holds byte-wide registers; others via hi words
        if (a == PIOC_OFS_CTRL) begin
          if (st_r.wstrb[0]) begin
            st_nxt.crossbar_enable = st_r.wdata[PIOC_BIT_XBAR_EN];
            st_nxt.global_pullup_disable = st_r.wdata[PIOC_BIT_PU_DIS];
          end
        end else if (a == PIOC_OFS_MDIN) begin
          for (int b = 0; b < 32; b++)
            if (st_r.wstrb[b/8]) st_nxt.pin_input_mode_bits[b] = st_r.wdata[b];
        end else if (a == PIOC_OFS_MDOUT) begin
          for (int b = 0; b < 32; b++)
            if (st_r.wstrb[b/8]) st_nxt.pin_output_mode_bits[b] = st_r.wdata[b];
        end else if (a == PIOC_OFS_LATCH) begin
          for (int b = 0; b < 32; b++)
            if (st_r.wstrb[b/8]) st_nxt.latch[b] = st_r.wdata[b];
        end else if (a == PIOC_OFS_XSEL0) begin
          if (st_r.wstrb[0]) st_nxt.crossbar_select_first = st_r.wdata[7:0];
        end else if (a == PIOC_OFS_XSEL1) begin
          if (st_r.wstrb[0]) st_nxt.crossbar_select_second = st_r.wdata[7:0];
        end else if (a == PIOC_OFS_XSEL2) begin
          if (st_r.wstrb[0]) st_nxt.crossbar_select_third = st_r.wdata[7:0];
        end else if (a == PIOC_OFS_MDIN_HI) begin
          if (st_r.wstrb[0]) st_nxt.pin_input_mode_bits[32] = st_r.wdata[0];
        end else if (a == PIOC_OFS_MDOUT_HI) begin
          if (st_r.wstrb[0]) st_nxt.pin_output_mode_bits[32] = st_r.wdata[0];
        end else if (a == PIOC_OFS_LATCH_HI) begin
          if (st_r.wstrb[0]) st_nxt.latch[32] = st_r.wdata[0];
        end else if (a == PIOC_OFS_PADIN || a == PIOC_OFS_PADIN_HI) begin
          ok = 1'b1; // Read-only, write ignored
        end else begin
          ok = 1'b0; // Unmapped
        end
        st_nxt.bresp = ok ? PIOC_RESP_OKAY : PIOC_RESP_SLVERR;
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got = 1'b0;
        st_nxt.wst = PIOC_RESP;
      end
    end else if (s_axi_bready) begin
      st_nxt.wst = PIOC_IDLE;
    end
    // Read channel: one-cycle decode after address accepted
    if (st_r.rst == PIOC_IDLE) begin
      if (s_axi_arvalid) begin
        ok = 1'b1;
        a = s_axi_araddr;
        if (a == PIOC_OFS_CTRL) begin
          rd[PIOC_BIT_XBAR_EN] = st_r.crossbar_enable;
          rd[PIOC_BIT_PU_DIS] = st_r.global_pullup_disable;
        end else if (a == PIOC_OFS_MDIN) rd = st_r.pin_input_mode_bits[31:0];
        else if (a == PIOC_OFS_MDOUT) rd = st_r.pin_output_mode_bits[31:0];
        else if (a == PIOC_OFS_LATCH) rd = pin_read[31:0]; // pad, not latch
        else if (a == PIOC_OFS_PADIN) rd = st_r.latch[31:0];
        else if (a == PIOC_OFS_XSEL0) rd[7:0] = st_r.crossbar_select_first;
        else if (a == PIOC_OFS_XSEL1) rd[7:0] = st_r.crossbar_select_second;
        else if (a == PIOC_OFS_XSEL2) rd[7:0] = st_r.crossbar_select_third;
        else if (a == PIOC_OFS_MDIN_HI) rd[0] = st_r.pin_input_mode_bits[32];
        else if (a == PIOC_OFS_MDOUT_HI) rd[0] = st_r.pin_output_mode_bits[32];
        else if (a == PIOC_OFS_LATCH_HI) rd[0] = pin_read[32];
        else if (a == PIOC_OFS_PADIN_HI) rd[0] = st_r.latch[32];
        else ok = 1'b0;
        st_nxt.rdata = rd;
        st_nxt.rresp = ok ? PIOC_RESP_OKAY : PIOC_RESP_SLVERR;
        st_nxt.rst = PIOC_RESP;
      end
    end else if (s_axi_rready) begin
      st_nxt.rst = PIOC_IDLE;
    end
    // Pad cells: registered so every pad output comes from a flip-flop
    for (int i = 0; i < NPINS; i++) begin
      if (!st_r.crossbar_enable) begin
        st_nxt.pad.oe[i] = 1'b0;
        st_nxt.pad.out[i] = 1'b0;
        st_nxt.pad.ie[i] = st_r.pin_input_mode_bits[i];
        st_nxt.pad.pu[i] = st_r.pin_input_mode_bits[i];
      end else if (!st_r.pin_input_mode_bits[i]) begin
        st_nxt.pad.oe[i] = 1'b0;
        st_nxt.pad.out[i] = 1'b0;
        st_nxt.pad.ie[i] = 1'b0;
        st_nxt.pad.pu[i] = 1'b0;
      end else begin
        st_nxt.pad.out[i] = drv_val[i];
        // Open-drain only drives low; push-pull drives both levels
        st_nxt.pad.oe[i] = drv_req[i] &&
          (st_r.pin_output_mode_bits[i] || !drv_val[i]);
        st_nxt.pad.ie[i] = 1'b1;
        st_nxt.pad.pu[i] = !st_r.global_pullup_disable &&
          !(st_nxt.pad.oe[i] && !drv_val[i]);
      end
    end
    // Debug pin bypasses the crossbar enable gate while the link drives
    if (debug_link_data_oe) begin
      st_nxt.pad.out[PIOC_DBG_PIN] = debug_link_data_out;
      st_nxt.pad.oe[PIOC_DBG_PIN] = 1'b1;
      st_nxt.pad.pu[PIOC_DBG_PIN] = 1'b0;
    end
    st_nxt.pin_to_periph = periph_pin;
    st_nxt.dbg_in = pad_sync[PIOC_DBG_PIN];
    // Handshakes follow the next channel state so each output is a flop
    st_nxt.aw_rdy = (st_nxt.wst == PIOC_IDLE) && !st_nxt.aw_got;
    st_nxt.w_rdy = (st_nxt.wst == PIOC_IDLE) && !st_nxt.w_got;
    st_nxt.ar_rdy = (st_nxt.rst == PIOC_IDLE);
    st_nxt.b_vld = (st_nxt.wst == PIOC_RESP);
    st_nxt.r_vld = (st_nxt.rst == PIOC_RESP);
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.pin_input_mode_bits <= PIOC_RST_MDIN;
      st_r.pin_output_mode_bits <= PIOC_RST_MDOUT;
      st_r.latch <= PIOC_RST_LATCH;
      st_r.pad.pu <= '1;
      st_r.pad.ie <= '1;
      {st_r.aw_rdy, st_r.w_rdy, st_r.ar_rdy} <= 3'h7; // Idle channels accept at once
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Handshake outputs come straight from their own flops
  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_bvalid = st_r.b_vld;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_rvalid = st_r.r_vld;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign pad = st_r.pad;
  assign periph_in = st_r.pin_to_periph;
  assign debug_link_data_in = st_r.dbg_in;

  // Checks
  // Pad controls lag the register bits by one edge, hence the past values
  chk_reset_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ce) && !$past(st_r.crossbar_enable) && !$past(debug_link_data_oe)
    |-> pad.oe == '0) else $error("pad driven before crossbar on");
  chk_analog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $past(ce) && !debug_link_data_oe && !$past(st_r.pin_input_mode_bits[0])
    |-> !pad.pu[0] && !pad.ie[0]) else $error("analog pin not isolated");
  chk_analog_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_read[0] |-> st_r.pin_input_mode_bits[0]) else $error("analog pin read nonzero");
  chk_od_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ce) && pad.oe[1] && !$past(st_r.pin_output_mode_bits[1])
    |-> !pad.out[1]) else $error("open-drain drove high");
  chk_pullup_low: assert property (@(posedge aclk) disable iff (!aresetn)
    pad.oe[2] && !pad.out[2] |-> !pad.pu[2]) else $error("pull-up on while low");
  chk_pullup_glob: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.crossbar_enable && st_r.global_pullup_disable && ce && $past(ce) &&
    $past(st_r.global_pullup_disable) && $past(st_r.crossbar_enable)
    |-> pad.pu[31:0] == '0) else $error("pull-up on under global disable");
  // Reset clears both stages, so the two edges after release are skipped
  chk_sync_path: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $past(ce) && $past(ce, 2) && $past(aresetn) && $past(aresetn, 2)
    |-> pad_sync == $past(pad_in, 2)) else $error("pad sync latency wrong");
  chk_dbg_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && debug_link_data_oe |=> !ce || pad.oe[PIOC_DBG_PIN])
    else $error("debug pin not driven");
  chk_bus_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid) else $error("read not answered");
  cov_xbar_on: cover property (@(posedge aclk) $rose(st_r.crossbar_enable));
  cov_od_float: cover property (@(posedge aclk) st_r.crossbar_enable &&
    !st_r.pin_output_mode_bits[3] && st_r.latch[3] && !pad.oe[3]);
  cov_xbar_claim: cover property (@(posedge aclk) xbar_claim[0]);
  cov_dbg: cover property (@(posedge aclk) debug_link_data_oe);
endmodule // pioc_top

// File: tb/pioc_board.sv
// Board-side model: external drivers, pull-ups and resolved pad levels
`timescale 1ns/1ps
module pioc_board (
  input wire logic aclk, // System clock, paces the float pattern
  input wire pioc_pkg::pioc_pad_type pad, // Device pad controls
  input wire logic [32:0] ext_oe, // Board drives the pin
  input wire logic [32:0] ext_val, // Board drive level
  output logic [32:0] level // Resolved pad level
);
  import pioc_pkg::*;
  logic [32:0] float_r = 33'h0; // Pattern shown by undriven pins
  // A floating pad toggles each cycle so a stale level never passes for a real one
  always_ff @(posedge aclk) begin
    float_r <= ~float_r;
  end
  // Device drive wins, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 33; i++) begin
      if (pad.oe[i]) begin // Device drives the pad
        level[i] = pad.out[i];
      end else if (ext_oe[i]) begin // Board drives the pad
        level[i] = ext_val[i];
      end else if (pad.pu[i]) begin // Weak pull-up holds it high
        level[i] = 1'b1;
      end else begin // Nothing holds it
        level[i] = float_r[i];
      end
    end
  end
endmodule // pioc_board

// File: tb/tb_pioc_top.sv
// Self-checking bench for the port I/O cell block against a behavioural model
`timescale 1ns/1ps
module tb_pioc_top;
  import pioc_pkg::*;
  logic aclk = 1'b0; // System clock
  logic aresetn = 1'b0; // Reset, active low
  logic [7:0] awaddr = 8'h0, araddr = 8'h0; // Bus addresses
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0; // Write data
  logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
  logic [1:0] bresp, rresp; // Responses
  logic [31:0] rdata; // Read data
  pioc_pad_type pad; // Pad controls
  pioc_periph_type periph = {24'h0, 24'hFFFFFF}; // Peripheral requests, all drive at first
  logic [23:0] periph_in; // Pad levels seen by peripherals
  logic dbg_oe = 1'b0, dbg_out = 1'b0, dbg_in; // Debug link on the shared pin
  logic ce = 1'b1; // Clock enable, dropped once per pass
  logic [32:0] lvl, ext_oe = 33'h0, ext_val = 33'h0; // Board side
  logic [32:0] m_mdin, m_mdout, m_latch; // Model mode and latch bits
  logic [1:0] m_ctrl; // Model control bits
  logic [23:0] m_sel, e_pin; // Model selects and peripheral levels
  logic [32:0] e_oe, e_out, e_pu, pm, e_lvl; // Model pad view
  logic [31:0] d, r; // Scratch words
  logic [15:0] lfsr_r = 16'h8AB6; // Random source
  logic [7:0] ra [12]; // Reset table addresses
  logic [31:0] rv [12]; // Reset table values
  int errors = 0;
  int checked = 0;

  pioc_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(lvl),
    .pad(pad), .periph(periph), .periph_in(periph_in), .debug_link_data_oe(dbg_oe),
    .debug_link_data_out(dbg_out), .debug_link_data_in(dbg_in));
  pioc_board board (.aclk(aclk), .pad(pad), .ext_oe(ext_oe), .ext_val(ext_val), .level(lvl));

  // Clock at 200 MHz
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic report_and_stop();
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Sixteen-bit shift register, one bit per step
  function automatic void rnd(output logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v = {v[30:0], lfsr_r[0]};
    end
  endfunction

  // Bus write: address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the response
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1;
        bready <= 1'b0;
        cmp("bresp", e, bresp);
      end
    end
  endtask

  // Bus read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e = 2'h0);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1;
        rready <= 1'b0;
        v = rdata;
        cmp("rresp", e, rresp);
      end
    end
  endtask

  // Behavioural pad model; crossbar hands enabled peripherals the next digital pin
  task automatic model();
    int p;
    int own [33];
    logic v;
    p = 0;
    e_pin = 24'h0;
    for (int i = 0; i < 33; i++) own[i] = -1;
    for (int k = 0; k < 24; k++) begin
      if (m_ctrl[0] && m_sel[k]) begin
        while (p < 32 && !m_mdin[p]) p++;
        if (p < 32) own[p] = k;
        p++;
      end
    end
    for (int i = 0; i < 33; i++) begin
      v = own[i] >= 0 ? periph.out[own[i]] : m_latch[i];
      if (i == 32 && dbg_oe) begin
        e_oe[i] = 1'b1;
        e_out[i] = dbg_out;
      end else begin // Open-drain only sinks, push-pull drives both
        e_oe[i] = m_ctrl[0] && m_mdin[i] && (own[i] < 0 || periph.oe[own[i]]) &&
          (m_mdout[i] || !v);
        e_out[i] = v;
      end
      e_pu[i] = m_mdin[i] && !(e_oe[i] && !e_out[i]) && !m_ctrl[1];
      // Pull-up while driving high, or disabled before the crossbar, is left open
      pm[i] = !(e_oe[i] && e_out[i]) && !(!m_ctrl[0] && m_ctrl[1]);
      e_lvl[i] = e_oe[i] ? e_out[i] : ext_val[i];
      if (own[i] >= 0) e_pin[own[i]] = e_lvl[i];
    end
  endtask

  // Watchdog cuts a hang well past the expected run length
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    report_and_stop();
  end

  initial begin
    ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
    rv = '{32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0,
      32'h1, 32'h0, 32'h1, 32'h1};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    // Undriven board: every cell Hi-Z with pull-up, reads high through the pull-ups
    cmp("oe", 33'h0, pad.oe);
    cmp("pu", 33'h1FFFFFFFF, pad.pu);
    cmp("ie", 33'h1FFFFFFFF, pad.ie);
    for (int i = 0; i < 12; i++) begin
      rd(ra[i], r);
      cmp("reset read", rv[i], r);
    end
    rd(8'h30, r, PIOC_RESP_SLVERR);
    cmp("unmapped read", 33'h0, r);
    wr(8'h30, 32'hFFFFFFFF, PIOC_RESP_SLVERR);
    ext_oe <= 33'h1FFFFFFFF;
    // Random configurations, each checked at the pads and through the bus
    for (int n = 0; n < 40; n++) begin
      rnd(d);
      m_mdin = {d[0], 32'h0};
      rnd(m_mdin[31:0]);
      rnd(m_mdout[31:0]);
      rnd(m_latch[31:0]);
      rnd(d);
      m_mdout[32] = d[1];
      m_latch[32] = d[2];
      m_ctrl = {d[3], d[4] | d[5]};
      m_sel = d[31:8];
      dbg_oe <= d[6];
      dbg_out <= d[7];
      if (d[6]) m_mdin[32] = 1'b1;
      rnd(d);
      periph.out <= d[23:0];
      rnd(r);
      ext_val <= {d[31], r};
      periph.oe <= r[31:8]; // Some peripherals leave their pins undriven
      wr(8'h04, m_mdin[31:0]);
      wr(8'h20, {31'h0, m_mdin[32]});
      wr(8'h08, m_mdout[31:0]);
      wr(8'h24, {31'h0, m_mdout[32]});
      wr(8'h0C, m_latch[31:0]);
      wr(8'h28, {31'h0, m_latch[32]});
      wr(8'h14, {24'h0, m_sel[7:0]});
      wr(8'h18, {24'h0, m_sel[15:8]});
      wr(8'h1C, {24'h0, m_sel[23:16]});
      wr(8'h00, {30'h0, m_ctrl});
      repeat (6) @(posedge aclk);
      model();
      cmp("oe", e_oe, pad.oe);
      cmp("out", e_out & e_oe, pad.out & e_oe);
      cmp("pu", e_pu & pm, pad.pu & pm);
      cmp("ie", m_mdin, pad.ie);
      cmp("periph_in", {9'h0, e_pin}, {9'h0, periph_in});
      if (m_mdin[32]) cmp("debug in", {32'h0, e_lvl[32]}, {32'h0, dbg_in});
      rd(8'h0C, r);
      cmp("port read", m_mdin[31:0] & e_lvl[31:0], r);
      rd(8'h28, r);
      cmp("port read top", m_mdin[32] & e_lvl[32], r);
      rd(8'h10, r);
      cmp("latch", m_latch[31:0], r);
      // With the clock enable low a flipped debug request must not reach the pad
      ce <= 1'b0;
      dbg_oe <= ~dbg_oe;
      repeat (3) @(posedge aclk);
      cmp("frozen oe", e_oe, pad.oe);
      ce <= 1'b1;
      dbg_oe <= ~dbg_oe;
    end
    report_and_stop();
  end
endmodule // tb_pioc_top
